/* File: dv/tb_top_level_irq_enable_pend.sv */
`timescale 1ns/1ps
module tb_top_level_irq_enable_pend;
  import tlie_pkg::*;
  // ==========================================================
  // stimulus and observed nets
  logic        core_clk_in = 1'h0;
  logic        arst_n_in   = 1'h0;
  logic        ce          = 1'h1;
  logic [16:0] src         = 17'h00000;
  logic        hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [16:0] enable, pending;
  int          err_total   = 0;
  int          checks      = 0;

  // 250 MHz clock
  always #2 core_clk_in = ~core_clk_in;

  tlie_top tlie_top_inst (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .ce_in(ce),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp),
    .timer_one_source_in(src[0]), .timer_two_source_in(src[1]),
    .management_source_in(src[2]), .baseband_source_in(src[3]),
    .sleep_timer_source_in(src[4]), .serial_ctrl_one_source_in(src[5]),
    .serial_ctrl_two_source_in(src[6]), .security_source_in(src[7]),
    .mac_timer_source_in(src[8]), .mac_transmit_source_in(src[9]),
    .mac_receive_source_in(src[10]), .adc_source_in(src[11]),
    .ext_request_a_source_in(src[12]), .ext_request_b_source_in(src[13]),
    .ext_request_c_source_in(src[14]), .ext_request_d_source_in(src[15]),
    .debug_source_in(src[16]), .enable_out(enable), .pending_out(pending), .irq_out(irq));

  tlie_ahb_master tlie_ahb_master_inst (.core_clk_in(core_clk_in), .hready_in(hready),
    .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
    .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

  // ==========================================================
  // shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  // two edges let registered outputs settle before they are looked at
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] d;
    tlie_ahb_master_inst.xfer(1'h1, a, v, d);
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] d;
    tlie_ahb_master_inst.xfer(1'h0, a, 32'h00000000, d);
    chk(d, exp, msg);
    chk({31'h0, hresp}, 32'h00000000, "okay resp");
  endtask : rd
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report

  // ==========================================================
  // scenarios
  // all clear after reset
  task automatic t_reset;
    chk({15'h0, enable}, 32'h00000000, "enable rst");
    chk({15'h0, pending}, 32'h00000000, "pending rst");
    rd(TLIE_ADDR_EN_SET, 32'h00000000, "set rst");
    rd(TLIE_ADDR_EN_CLR, 32'h00000000, "clr rst");
    rd(TLIE_ADDR_PND_SET, 32'h00000000, "pend rst");
    rd(TLIE_ADDR_MASK, 32'h00000000, "mask rst");
    $display("test reset done");
  endtask : t_reset
  // set and clear share one vector
  task automatic t_enable;
    for (int i = 0; i < 17; i++) begin
      wr(TLIE_ADDR_EN_SET, 32'h1 << i);
      chk({15'h0, enable}, (32'h2 << i) - 32'h1, "enable walk");
    end
    wr(TLIE_ADDR_EN_SET, 32'h00000000);
    chk({15'h0, enable}, 32'h0001ffff, "set zero");
    rd(TLIE_ADDR_EN_CLR, 32'h0001ffff, "clr read");
    wr(TLIE_ADDR_EN_CLR, 32'h0000aaaa);
    chk({15'h0, enable}, 32'h00015555, "clr some");
    wr(TLIE_ADDR_EN_CLR, 32'h00000000);
    chk({15'h0, enable}, 32'h00015555, "clr zero");
    rd(TLIE_ADDR_EN_SET, 32'h00015555, "set read");
    wr(TLIE_ADDR_EN_CLR, 32'hffffffff);
    wr(32'he000e104, 32'hffffffff);
    chk({15'h0, enable}, 32'h00000000, "unmapped wr");
    rd(32'he000e104, 32'h00000000, "unmapped rd");
    $display("test enable done");
  endtask : t_enable
  task automatic t_pend;
    wr(TLIE_ADDR_PND_SET, 32'h00000000);
    chk({15'h0, pending}, 32'h00000000, "pend zero");
    for (int i = 16; i >= 0; i--) begin
      wr(TLIE_ADDR_PND_SET, 32'h1 << i);
      chk({15'h0, pending}, 32'h0001ffff & ~((32'h1 << i) - 32'h1), "pend walk");
    end
    rd(TLIE_ADDR_PND_SET, 32'h0001ffff, "pend read");
    wr(TLIE_ADDR_STATUS, 32'h0001ffff);
    chk({15'h0, pending}, 32'h00000000, "pend ack");
    $display("test pend done");
  endtask : t_pend
  // each named source lands on its bit
  task automatic t_sources;
    for (int i = 0; i < 17; i++) begin
      @(posedge core_clk_in);
      src <= 17'h1 << i;
      @(posedge core_clk_in);
      src <= 17'h00000;
      repeat (2) @(posedge core_clk_in);
      #1;
      chk({15'h0, pending}, 32'h1 << i, "source bit");
      wr(TLIE_ADDR_STATUS, 32'h1 << i);
    end
    $display("test sources done");
  endtask : t_sources
  // interrupt raised, masked, cleared; disabled source stays quiet
  task automatic t_irq;
    wr(TLIE_ADDR_MASK, 32'h00000018);
    wr(TLIE_ADDR_PND_SET, 32'h00000010);
    chk({31'h0, irq}, 32'h0, "disabled quiet");
    wr(TLIE_ADDR_EN_SET, 32'h00000008);
    wr(TLIE_ADDR_PND_SET, 32'h00000008);
    chk({31'h0, irq}, 32'h1, "irq raise");
    rd(TLIE_ADDR_STATUS, 32'h00000008, "status");
    wr(TLIE_ADDR_MASK, 32'h00000000);
    chk({31'h0, irq}, 32'h0, "irq mask");
    wr(TLIE_ADDR_MASK, 32'h00000008);
    chk({31'h0, irq}, 32'h1, "irq unmask");
    wr(TLIE_ADDR_STATUS, 32'h00000018);
    chk({31'h0, irq}, 32'h0, "irq clear");
    chk({15'h0, pending}, 32'h00000000, "pend cleared");
    $display("test irq done");
  endtask : t_irq
  // clock enable low: a source pulse seen only while frozen is lost
  task automatic t_ce;
    @(posedge core_clk_in);
    ce  <= 1'h0;
    src <= 17'h00001;
    @(posedge core_clk_in);
    src <= 17'h00000;
    @(posedge core_clk_in);
    ce  <= 1'h1;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk({15'h0, pending}, 32'h00000000, "ce frozen");
    $display("test ce done");
  endtask : t_ce
  // a reset in mid-run clears what earlier writes set
  task automatic t_rerst;
    wr(TLIE_ADDR_EN_SET, 32'h0001ffff);
    wr(TLIE_ADDR_PND_SET, 32'h00000004);
    @(posedge core_clk_in);
    arst_n_in <= 1'h0;
    repeat (3) @(posedge core_clk_in);
    arst_n_in <= 1'h1;
    @(posedge core_clk_in);
    #1;
    chk({15'h0, enable}, 32'h00000000, "enable rerst");
    chk({15'h0, pending}, 32'h00000000, "pending rerst");
    chk({31'h0, irq}, 32'h0, "irq rerst");
    rd(TLIE_ADDR_EN_CLR, 32'h00000000, "clr rerst");
    rd(TLIE_ADDR_MASK, 32'h00000000, "mask rerst");
    $display("test rerst done");
  endtask : t_rerst

  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge core_clk_in);
    arst_n_in <= 1'h1;
    @(posedge core_clk_in);
    #1;
    t_reset();
    t_enable();
    t_pend();
    t_sources();
    t_irq();
    t_ce();
    t_rerst();
    final_report();
  end
  // the run needs about 460 cycles; allow over thirty times that
  initial begin
    #60000;
    err_total++;
    $display("unexpected at %0t: watchdog", $time);
    final_report();
  end
endmodule : tb_top_level_irq_enable_pend

/* File: dv/tlie_ahb_master.sv */
`timescale 1ns/1ps
// ==========================================================
// bus master standing in for core software
module tlie_ahb_master
  import tlie_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  output logic             hsel_out,
  output logic      [31:0] haddr_out,
  output logic      [1:0]  htrans_out,
  output logic             hwrite_out,
  output logic      [2:0]  hsize_out,
  output logic      [31:0] hwdata_out
);
  // idle bus from time zero
  initial begin
    hsel_out   = 1'h0;
    haddr_out  = 32'h00000000;
    htrans_out = 2'h0;
    hwrite_out = 1'h0;
    hsize_out  = TLIE_HSIZE_WORD;
    hwdata_out = 32'h00000000;
  end
  // one single word; stale data lines keep toggling so no old value is reused
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    @(posedge core_clk_in);
    hsel_out   <= 1'h1;
    haddr_out  <= addr;
    htrans_out <= 2'h2;
    hwrite_out <= wr;
    hsize_out  <= TLIE_HSIZE_WORD;
    hwdata_out <= ~hwdata_out;
    do @(posedge core_clk_in); while (hready_in !== 1'h1);
    hsel_out   <= 1'h0;
    htrans_out <= 2'h0;
    hwdata_out <= wr ? wdata : ~hwdata_out;
    do @(posedge core_clk_in); while (hready_in !== 1'h1);
    rdata = hrdata_in;
  endtask : xfer
endmodule : tlie_ahb_master

/* File: rtl/tlie_bank_if.sv */
`timescale 1ns/1ps
// ==========================================================
// per-source enable and pending bank link
interface tlie_bank_if;
  logic        ce;
  logic [16:0] en_set;
  logic [16:0] en_clr;
  logic [16:0] pnd_set;
  logic [16:0] pnd_clr;
  logic [16:0] src;
  logic [16:0] en;
  logic [16:0] pnd;
  logic [16:0] next_en;
  logic [16:0] next_pnd;

  modport ctrl (output ce, en_set, en_clr, pnd_set, pnd_clr, src,
                input  en, pnd, next_en, next_pnd);
  modport bank (input  ce, en_set, en_clr, pnd_set, pnd_clr, src,
                output en, pnd, next_en, next_pnd);
endinterface : tlie_bank_if

/* File: rtl/tlie_pkg.sv */
package tlie_pkg;

  // ==========================================================
  // source layout
  localparam int unsigned TLIE_NSRC = 17;
  localparam int unsigned TLIE_BIT_TIMER_ONE     = 0;
  localparam int unsigned TLIE_BIT_TIMER_TWO     = 1;
  localparam int unsigned TLIE_BIT_MANAGEMENT    = 2;
  localparam int unsigned TLIE_BIT_BASEBAND      = 3;
  localparam int unsigned TLIE_BIT_SLEEP_TIMER   = 4;
  localparam int unsigned TLIE_BIT_SERIAL_ONE    = 5;
  localparam int unsigned TLIE_BIT_SERIAL_TWO    = 6;
  localparam int unsigned TLIE_BIT_SECURITY      = 7;
  localparam int unsigned TLIE_BIT_MAC_TIMER     = 8;
  localparam int unsigned TLIE_BIT_MAC_TRANSMIT  = 9;
  localparam int unsigned TLIE_BIT_MAC_RECEIVE   = 10;
  localparam int unsigned TLIE_BIT_ADC           = 11;
  localparam int unsigned TLIE_BIT_EXT_REQUEST_A = 12;
  localparam int unsigned TLIE_BIT_EXT_REQUEST_B = 13;
  localparam int unsigned TLIE_BIT_EXT_REQUEST_C = 14;
  localparam int unsigned TLIE_BIT_EXT_REQUEST_D = 15;
  localparam int unsigned TLIE_BIT_DEBUG         = 16;

  // ==========================================================
  // register map, byte addresses
  localparam logic [31:0] TLIE_ADDR_EN_SET  = 32'he000e100;
  localparam logic [31:0] TLIE_ADDR_EN_CLR  = 32'he000e180;
  localparam logic [31:0] TLIE_ADDR_PND_SET = 32'he000e200;
  localparam logic [31:0] TLIE_ADDR_STATUS  = 32'he000e380;
  localparam logic [31:0] TLIE_ADDR_MASK    = 32'he000e384;

  // ==========================================================
  // reset values and bus codes
  localparam logic [16:0] TLIE_SRC_RST      = 17'h00000;
  localparam logic [31:0] TLIE_RDATA_RST    = 32'h00000000;
  localparam logic [14:0] TLIE_RD_PAD       = 15'h0000;
  localparam logic [2:0]  TLIE_HSIZE_WORD   = 3'h2;
  localparam logic        TLIE_HRESP_OKAY   = 1'h0;

  typedef enum {
    TLIE_REG_NONE,
    TLIE_REG_EN_SET,
    TLIE_REG_EN_CLR,
    TLIE_REG_PND_SET,
    TLIE_REG_STATUS,
    TLIE_REG_MASK
  } tlie_reg_t;

endpackage : tlie_pkg

/* File: rtl/tlie_src_bank.sv */
`timescale 1ns/1ps
module tlie_src_bank
  import tlie_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic arst_n_in,
  tlie_bank_if.bank bus
);

  // ==========================================================
  // next enable and pending value, one slice per source
  for (genvar i = 0; i < TLIE_NSRC; i++) begin : g_src
    // clear-enable write ones; zeros leave enable alone
    assign bus.next_en[i] = (bus.en[i] | bus.en_set[i]) & ~bus.en_clr[i];
    // pend on write one or source; set beats ack
    assign bus.next_pnd[i] = bus.pnd_set[i] | bus.src[i] | (bus.pnd[i] & ~bus.pnd_clr[i]);
  end

  // nothing pending after reset
  // one process for the whole vector, so every flop has a single writer
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus.en  <= TLIE_SRC_RST;
      bus.pnd <= TLIE_SRC_RST;
    end else if (bus.ce) begin
      bus.en  <= bus.next_en;
      bus.pnd <= bus.next_pnd;
    end
  end

endmodule : tlie_src_bank

/* File: rtl/tlie_top.sv */
`timescale 1ns/1ps
module tlie_top
  import tlie_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        timer_one_source_in,
  input  wire logic        timer_two_source_in,
  input  wire logic        management_source_in,
  input  wire logic        baseband_source_in,
  input  wire logic        sleep_timer_source_in,
  input  wire logic        serial_ctrl_one_source_in,
  input  wire logic        serial_ctrl_two_source_in,
  input  wire logic        security_source_in,
  input  wire logic        mac_timer_source_in,
  input  wire logic        mac_transmit_source_in,
  input  wire logic        mac_receive_source_in,
  input  wire logic        adc_source_in,
  input  wire logic        ext_request_a_source_in,
  input  wire logic        ext_request_b_source_in,
  input  wire logic        ext_request_c_source_in,
  input  wire logic        ext_request_d_source_in,
  input  wire logic        debug_source_in,
  output logic      [16:0] enable_out,
  output logic      [16:0] pending_out,
  output logic             irq_out
);

  // bank link; the bank owns the enable and pending flops
  tlie_bank_if bank_if ();

  // ==========================================================
  // per-source enable and pending bank
  tlie_src_bank tlie_src_bank_inst (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .bus         (bank_if.bank)
  );

  // ==========================================================
  // source wiring
  // sources are same-clock logic, so no synchroniser stands in front
  logic [16:0] src_vec;
  assign src_vec[TLIE_BIT_TIMER_ONE]     = timer_one_source_in;
  assign src_vec[TLIE_BIT_TIMER_TWO]     = timer_two_source_in;
  assign src_vec[TLIE_BIT_MANAGEMENT]    = management_source_in;
  assign src_vec[TLIE_BIT_BASEBAND]      = baseband_source_in;
  assign src_vec[TLIE_BIT_SLEEP_TIMER]   = sleep_timer_source_in;
  assign src_vec[TLIE_BIT_SERIAL_ONE]    = serial_ctrl_one_source_in;
  assign src_vec[TLIE_BIT_SERIAL_TWO]    = serial_ctrl_two_source_in;
  assign src_vec[TLIE_BIT_SECURITY]      = security_source_in;
  assign src_vec[TLIE_BIT_MAC_TIMER]     = mac_timer_source_in;
  assign src_vec[TLIE_BIT_MAC_TRANSMIT]  = mac_transmit_source_in;
  assign src_vec[TLIE_BIT_MAC_RECEIVE]   = mac_receive_source_in;
  assign src_vec[TLIE_BIT_ADC]           = adc_source_in;
  assign src_vec[TLIE_BIT_EXT_REQUEST_A] = ext_request_a_source_in;
  assign src_vec[TLIE_BIT_EXT_REQUEST_B] = ext_request_b_source_in;
  assign src_vec[TLIE_BIT_EXT_REQUEST_C] = ext_request_c_source_in;
  assign src_vec[TLIE_BIT_EXT_REQUEST_D] = ext_request_d_source_in;
  assign src_vec[TLIE_BIT_DEBUG]         = debug_source_in;

  // ==========================================================
  // address phase decode
  tlie_reg_t ap_sel;
  tlie_reg_t dp_sel;
  logic      dp_write;
  wire       ap_valid   = hsel_in & htrans_in[1] & hready_in;
  wire       ap_word    = (hsize_in == TLIE_HSIZE_WORD);
  wire       hit_en_set = (haddr_in == TLIE_ADDR_EN_SET);
  wire       hit_en_clr = (haddr_in == TLIE_ADDR_EN_CLR);
  wire       hit_pnd    = (haddr_in == TLIE_ADDR_PND_SET);
  wire       hit_stat   = (haddr_in == TLIE_ADDR_STATUS);
  wire       hit_mask   = (haddr_in == TLIE_ADDR_MASK);

  // unmapped or narrow accesses fall to none: read zero, write dropped
  assign ap_sel = !(ap_valid && ap_word) ? TLIE_REG_NONE    :
                  hit_en_set             ? TLIE_REG_EN_SET  :
                  hit_en_clr             ? TLIE_REG_EN_CLR  :
                  hit_pnd                ? TLIE_REG_PND_SET :
                  hit_stat               ? TLIE_REG_STATUS  :
                  hit_mask               ? TLIE_REG_MASK    : TLIE_REG_NONE;

  // address phase captured for the data phase
  // hwrite qualified by ap_valid so an idle cycle never strobes a write
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dp_sel   <= TLIE_REG_NONE;
      dp_write <= 1'b0;
    end else if (ce_in) begin
      dp_sel   <= ap_sel;
      dp_write <= hwrite_in & ap_valid;
    end
  end

  // ==========================================================
  // data phase write strobes
  // bits 31:17 of a write are ignored
  wire [16:0] wdata    = hwdata_in[16:0];
  wire        wr_en_s  = dp_write && (dp_sel == TLIE_REG_EN_SET);
  wire        wr_en_c  = dp_write && (dp_sel == TLIE_REG_EN_CLR);
  wire        wr_pnd_s = dp_write && (dp_sel == TLIE_REG_PND_SET);
  wire        wr_stat  = dp_write && (dp_sel == TLIE_REG_STATUS);
  wire        wr_mask  = dp_write && (dp_sel == TLIE_REG_MASK);

  assign bank_if.ce      = ce_in;
  assign bank_if.src     = src_vec;
  // only ones of a set-enable write reach the bank
  assign bank_if.en_set  = wr_en_s ? wdata : TLIE_SRC_RST;
  // only ones of a clear-enable write reach the bank
  assign bank_if.en_clr  = wr_en_c ? wdata : TLIE_SRC_RST;
  // only ones of a pending-set write reach the bank
  assign bank_if.pnd_set = wr_pnd_s ? wdata : TLIE_SRC_RST;
  // clearing a status bit also acknowledges that pending bit
  assign bank_if.pnd_clr = wr_stat ? wdata : TLIE_SRC_RST;

  // ==========================================================
  // interrupt status and mask
  logic [16:0] fire_q;
  logic [16:0] stat;
  logic [16:0] mask;
  // an event is a source becoming both pending and enabled
  // edge, not level: a source held high does not re-raise status after a clear
  wire  [16:0] fire      = bank_if.pnd & bank_if.en;
  wire  [16:0] evt       = fire & ~fire_q;
  // set wins over a clear landing in the same cycle
  wire  [16:0] next_stat = evt | (stat & ~bank_if.pnd_clr);
  wire  [16:0] next_mask = wr_mask ? wdata : mask;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fire_q <= TLIE_SRC_RST;
      stat   <= TLIE_SRC_RST;
      mask   <= TLIE_SRC_RST;
    end else if (ce_in) begin
      fire_q <= fire;
      stat   <= next_stat;
      mask   <= next_mask;
    end
  end

  // ==========================================================
  // read data, taken from next values so a read right after a write sees it
  logic [16:0] rd_val;
  // decoded in the address phase, so the data stand for one data phase only
  // both enable addresses return the shared enable vector
  assign rd_val = (ap_sel == TLIE_REG_EN_SET || ap_sel == TLIE_REG_EN_CLR) ? bank_if.next_en :
                  (ap_sel == TLIE_REG_PND_SET)                              ? bank_if.next_pnd :
                  (ap_sel == TLIE_REG_STATUS)                               ? next_stat :
                  (ap_sel == TLIE_REG_MASK)                                 ? next_mask :
                                                                              TLIE_SRC_RST;
  wire         rd_now      = ap_valid & ~hwrite_in;
  // upper bits pad to zero; outside a read data phase the bus sees zero
  wire  [31:0] next_hrdata = rd_now ? {TLIE_RD_PAD, rd_val} : TLIE_RDATA_RST;
  // irq follows next values so it moves at the same edge as status
  wire         next_irq    = |(next_stat & next_mask);

  // bus outputs registered; zero wait states, always okay
  // a fixed ready keeps the slave simple: no access ever needs a stall
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_out    <= TLIE_RDATA_RST;
      hreadyout_out <= 1'b1;
      hresp_out     <= TLIE_HRESP_OKAY;
    end else if (ce_in) begin
      hrdata_out    <= next_hrdata;
      hreadyout_out <= 1'b1;
      hresp_out     <= TLIE_HRESP_OKAY;
    end
  end

  // vector and interrupt outputs, copies of the bank and of the masked status
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      enable_out  <= TLIE_SRC_RST;
      pending_out <= TLIE_SRC_RST;
      irq_out     <= 1'b0;
    end else if (ce_in) begin
      enable_out  <= bank_if.next_en;
      pending_out <= bank_if.next_pnd;
      irq_out     <= next_irq;
    end
  end

  // ==========================================================
  // checks
  // helper for the reset checks; low only until the first edge after release
  logic post_rst;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      post_rst <= 1'b0;
    end else begin
      post_rst <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_en_set_ones: assert property (ce_in && wr_en_s |=>
      bank_if.en == ($past(bank_if.en) | $past(wdata)))
    else $error("set-enable write did not or in ones");
  a_en_clr_ones: assert property (ce_in && wr_en_c |=>
      bank_if.en == ($past(bank_if.en) & ~$past(wdata)))
    else $error("clear-enable write did not clear ones");
  // enables move only on enable writes
  a_en_only_wr: assert property (ce_in && !wr_en_s && !wr_en_c |=>
      $stable(bank_if.en))
    else $error("enable changed without an enable write");

  a_low_src_map: assert property (ce_in && timer_one_source_in |=>
      bank_if.pnd[0] && pending_out[0])
    else $error("timer one source not on bit 0");
  a_high_src_map: assert property (ce_in && debug_source_in |=>
      bank_if.pnd[16] && pending_out[16])
    else $error("debug source not on bit 16");

  a_reset_en_zero: assert property (!post_rst |->
      bank_if.en == TLIE_SRC_RST && enable_out == TLIE_SRC_RST)
    else $error("enables not zero after reset");
  a_unmapped_drop: assert property (ce_in && dp_write && dp_sel == TLIE_REG_NONE |=>
      $stable(bank_if.en) && $stable(mask))
    else $error("unmapped write changed state");
  a_clr_read_zero: assert property (ce_in && rd_now && ap_sel == TLIE_REG_EN_CLR
      && bank_if.next_en == TLIE_SRC_RST |=> hrdata_out == TLIE_RDATA_RST)
    else $error("clear-enable read not zero while all disabled");
  a_reset_pnd_zero: assert property (!post_rst |->
      bank_if.pnd == TLIE_SRC_RST && pending_out == TLIE_SRC_RST)
    else $error("pending not zero after reset");
  a_pnd_sticky: assert property (ce_in && !wr_stat |=>
      (bank_if.pnd & $past(bank_if.pnd)) == $past(bank_if.pnd))
    else $error("pending bit dropped without an acknowledge");
  a_pnd_set_ones: assert property (ce_in && wr_pnd_s |=>
      ((bank_if.pnd & $past(wdata)) == $past(wdata)) &&
      ((bank_if.pnd & ~$past(wdata)) == ($past(bank_if.pnd) & ~$past(wdata))) ||
      ($past(src_vec) != TLIE_SRC_RST) || $past(wr_stat))
    else $error("pending-set write wrong");
  a_en_read_shared: assert property (ce_in && rd_now && (ap_sel == TLIE_REG_EN_SET
      || ap_sel == TLIE_REG_EN_CLR) |=> hrdata_out == {TLIE_RD_PAD, bank_if.en})
    else $error("enable read not shared vector");
  a_rd_pad_zero: assert property (hrdata_out[31:17] == TLIE_RD_PAD)
    else $error("read data upper bits not zero");

  // status sticky until written
  a_stat_sticky: assert property (ce_in && !wr_stat |=>
      (stat & $past(stat)) == $past(stat))
    else $error("status bit dropped without a clear");
  // clock enable low freezes state
  a_ce_freeze: assert property (!ce_in |=>
      $stable(bank_if.en) && $stable(bank_if.pnd) && $stable(stat))
    else $error("state moved while clock enable low");
  // interrupt level from status and mask
  a_irq_follows: assert property (irq_out == |(stat & mask))
    else $error("irq output disagrees with status and mask");
  // bus answer always ready and okay
  a_bus_okay: assert property (hreadyout_out && hresp_out == TLIE_HRESP_OKAY)
    else $error("slave stalled or errored");

  // main scenarios
  c_en_set_write: cover property (ce_in && wr_en_s);
  c_pnd_read:     cover property (rd_now && ap_sel == TLIE_REG_PND_SET);
  c_irq_rise:     cover property ($rose(irq_out));
  c_stat_ack:     cover property (ce_in && wr_stat ##1 $fell(irq_out));
  c_ce_hold:      cover property (!ce_in ##1 ce_in);

endmodule : tlie_top
